// ---- bench/front_end_model.sv ----
// Behavioural filter front end facing the conversion sequencer.
// Assumes the bench sets the result to hand over and the reference state.
`timescale 1ns/1ps
module front_end_model (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  sampling,
  input  wire logic                  mod_clk_en,
  input  wire conv_seq_pkg::scaled_t result_set,
  input  wire logic                  ref_bad_set,
  output conv_seq_pkg::scaled_t      filt_result,
  output logic                       ref_bad,
  output logic [15:0]                sample_len,
  output logic [15:0]                mod_len
);
  import conv_seq_pkg::*;
  logic [15:0] cnt_r;
  logic [15:0] mod_r;
  // The filter output is only settled outside sampling; inside it the value
  // flips every cycle, so a capture at the wrong moment gives a wrong result.
  assign filt_result = sampling ? (result_set ^ {18{mod_clk_en}}) : result_set;
  assign ref_bad     = ref_bad_set;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r      <= 16'h0000;
      mod_r      <= 16'h0000;
      sample_len <= 16'h0000;
      mod_len    <= 16'h0000;
    end else if (sampling) begin
      cnt_r <= cnt_r + 16'h0001;
      mod_r <= mod_r + {15'h0000, mod_clk_en};
    end else if (cnt_r != 16'h0000) begin
      sample_len <= cnt_r;
      mod_len    <= mod_r;
      cnt_r      <= 16'h0000;
      mod_r      <= 16'h0000;
    end
  end
endmodule // front_end_model

// ---- bench/tb_sigma_delta_conversion_sequencer.sv ----
// Self-checking bench for the conversion sequencer.
// Assumes the design package, the register header and the front end model.
`timescale 1ns/1ps
module tb_sigma_delta_conversion_sequencer;
  import conv_seq_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  bus_req_s    bus_req = '0;
  logic [15:0] rdata;
  scaled_t     filt_result;
  scaled_t     result_set = '0;
  logic        ref_bad;
  logic        ref_bad_set = 1'b0;
  logic        mod_clk_en;
  logic        chop_reverse;
  logic        sampling;
  logic [2:0]  mux_chan;
  logic        ready_n;
  logic [15:0] sample_len;
  logic [15:0] mod_len;
  int          fail_count = 0;
  int          compares = 0;
  int          n;

  always #50 sys_clk = ~sys_clk;

  conv_seq u_dut (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .filt_result(filt_result), .ref_bad(ref_bad), .mod_clk_en(mod_clk_en),
    .chop_reverse(chop_reverse), .sampling(sampling), .mux_chan(mux_chan),
    .ready_n(ready_n));
  front_end_model u_fe (.sys_clk(sys_clk), .rstn(rstn), .sampling(sampling),
    .mod_clk_en(mod_clk_en), .result_set(result_set), .ref_bad_set(ref_bad_set),
    .filt_result(filt_result), .ref_bad(ref_bad), .sample_len(sample_len),
    .mod_len(mod_len));

  // ---------------------------------------------------------------
  // Access and check tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  function automatic logic cond(input int sel, input logic [2:0] ch);
    case (sel)
      0: return sampling === 1'b1;
      1: return sampling === 1'b0;
      2: return ready_n === 1'b0;
      default: return mux_chan === ch;
    endcase
  endfunction

  // Counts settled cycles until the condition holds; a hang ends the run.
  task automatic wait_for(input int sel, input logic [2:0] ch, output int cnt);
    cnt = 0;
    #1;
    while (!cond(sel, ch)) begin
      @(posedge sys_clk);
      #1;
      cnt++;
      if (cnt > 30000) begin
        fail_count++;
        $display("BAD t=%0t wait expired", $time);
        report_and_stop;
      end
    end
  endtask

  // One single conversion on channel 0, unchopped, filter word 1.
  task automatic run_case(input logic bip, input logic clamp, input logic rb,
                          input scaled_t val, input logic [15:0] exp_d,
                          input logic [15:0] exp_s);
    @(posedge sys_clk);
    result_set  <= val;
    ref_bad_set <= rb;
    wr(8'h10, {5'h00, 1'b1, bip, 1'b0, 8'h01});
    wr(8'h00, {5'h00, clamp, 2'b10, 8'h00});
    wait_for(0, 3'h0, n);
    check({15'h0000, n >= 43 && n <= 44}, 16'h0001);
    wait_for(1, 3'h0, n);
    wait_for(2, 3'h0, n);
    check({15'h0000, n >= 163 && n <= 165}, 16'h0001);
    check(sample_len, 16'h0020);
    check(mod_len, 16'h0010);
    rd_chk(8'h20, exp_s);
    rd_chk(8'h30, exp_d);
    rd_chk(8'h20, exp_s & 16'hFFFE);
    check({15'h0000, ready_n}, 16'h0001);
    $display("case %h finished", exp_d);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    check({15'h0000, ready_n}, 16'h0001);
    rd_chk(8'h10, 16'h0120);
    rd_chk(8'h00, 16'h0000);
    wr(8'h7F, 16'hFFFF);
    rd_chk(8'h7F, 16'h0000);
    $display("reset test finished");
    run_case(1'b1, 1'b0, 1'b1, 18'h00000, 16'h8000, 16'h0009);
    run_case(1'b1, 1'b0, 1'b0, 18'h07FFF, 16'hFFFF, 16'h0001);
    run_case(1'b1, 1'b0, 1'b0, 18'h3FFFF, 16'h7FFF, 16'h0005);
    run_case(1'b1, 1'b0, 1'b0, 18'h08000, 16'h0000, 16'h0003);
    run_case(1'b1, 1'b0, 1'b0, 18'h37FFF, 16'hFFFF, 16'h0007);
    run_case(1'b1, 1'b1, 1'b0, 18'h08000, 16'hFFFF, 16'h0003);
    run_case(1'b1, 1'b1, 1'b0, 18'h37FFF, 16'h0000, 16'h0007);
    run_case(1'b0, 1'b0, 1'b0, 18'h0FFFF, 16'hFFFF, 16'h0001);
    run_case(1'b0, 1'b0, 1'b0, 18'h10000, 16'h0000, 16'h0003);
    run_case(1'b0, 1'b0, 1'b0, 18'h3FFFF, 16'h0000, 16'h0007);
    run_case(1'b0, 1'b1, 1'b0, 18'h10000, 16'hFFFF, 16'h0003);
    // Channel 1 chopped with word 2, channel 3 unchopped with word 1.
    @(posedge sys_clk);
    result_set <= 18'h00100;
    wr(8'h10, 16'h0001);
    wr(8'h11, 16'h0502);
    wr(8'h13, 16'h0401);
    wr(8'h01, 16'h0000);
    wr(8'h00, 16'h0101);
    wait_for(0, 3'h0, n);
    check({15'h0000, chop_reverse}, 16'h0000);
    wait_for(1, 3'h0, n);
    wait_for(0, 3'h0, n);
    check(n[15:0], 16'd42);
    check({15'h0000, chop_reverse}, 16'h0001);
    check(sample_len, 16'h0040);
    wait_for(3, 3'h3, n);
    wait_for(2, 3'h0, n);
    check({15'h0000, n <= 3}, 16'h0001);
    wait_for(0, 3'h0, n);
    check({15'h0000, chop_reverse}, 16'h0000);
    wait_for(1, 3'h0, n);
    repeat (5) @(posedge sys_clk);
    #1;
    check({15'h0000, ready_n}, 16'h0001);
    check(sample_len, 16'h0020);
    wr(8'h01, 16'h0001);
    wait_for(3, 3'h1, n);
    wait_for(2, 3'h0, n);
    check({15'h0000, n <= 3}, 16'h0001);
    rd_chk(8'h31, 16'h0100);
    rd_chk(8'h02, 16'h0008);
    check({15'h0000, ready_n}, 16'h0001);
    rd_chk(8'h33, 16'h0100);
    $display("continuous test finished");
    // Land a data read of channel 3 exactly on its completing edge.
    @(posedge sys_clk);
    result_set <= 18'h00200;
    wait_for(3, 3'h3, n);
    wait_for(0, 3'h0, n);
    wait_for(1, 3'h0, n);
    repeat (161) @(posedge sys_clk);
    rd_chk(8'h33, 16'h0100);
    rd_chk(8'h23, 16'h0030);
    rd_chk(8'h02, 16'h0002);
    check({15'h0000, ready_n}, 16'h0001);
    rd_chk(8'h31, 16'h0200);
    wr(8'h00, 16'h0000);
    $display("discard test finished");
    report_and_stop;
  end
endmodule // tb_sigma_delta_conversion_sequencer

// ---- hdl/conv_seq.sv ----
// Per-channel conversion sequencer: phases, result coding, ready flags.
// Assumes one master clock, a filter front end that hands over a scaled
// result, and a reference comparator input from the analog domain.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`include "conv_seq_regs.svh"
module conv_seq (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire conv_seq_pkg::bus_req_s bus_req,
  output logic [15:0]                rdata,
  input  wire conv_seq_pkg::scaled_t filt_result,
  input  wire logic                  ref_bad,
  output logic                       mod_clk_en,
  output logic                       chop_reverse,
  output logic                       sampling,
  output logic [2:0]                 mux_chan,
  output logic                       ready_n
);
  import conv_seq_pkg::*;

  localparam int NCH = `CS_NCH;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_e              ph;
    logic [13:0]         cnt;
    logic [2:0]          chan;
    logic                modclk;
    logic [7:0]          mode;
    logic                ready_pin_function_select;
    logic [NCH-1:0][15:0] chset;
    logic [NCH-1:0][15:0] data;
    logic [NCH-1:0]      rdy;
    logic [NCH-1:0]      overrange_flag;
    logic [NCH-1:0]      sign;
    logic [NCH-1:0]      reference_missing_flag;
    logic                reference_missing_flag_seen;
    logic                pin_n;
    logic [15:0]         rdata;
    logic                ref_s1;
    logic                ref_s2;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  function automatic chan_cfg_s cfg_of(input logic [15:0] w);
    chan_cfg_s c;
    c.fw      = w[`CS_CHSET_FW_LSB +: 8];
    c.chop    = w[`CS_CHSET_CHOP_BIT];
    c.bipolar = w[`CS_CHSET_BIP_BIT];
    c.enable  = w[`CS_CHSET_EN_BIT];
    return c;
  endfunction

  // Sampling length in master cycles from the filter word.
  function automatic logic [13:0] sample_len(input logic [7:0] fw);
    return 14'(fw) * 14'(`CS_FW_SCALE);
  endfunction

  // ----------------------------------------------------------------
  // Result coding
  // ----------------------------------------------------------------
  chan_cfg_s   cur_cfg;
  logic [15:0] code;
  logic        code_ovr;
  logic        code_sign;
  logic [2:0]  next_chan;
  logic        any_en;
  logic [NCH-1:0] en_vec;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_en
      assign en_vec[gi] = st_r.chset[gi][`CS_CHSET_EN_BIT];
    end
  endgenerate

  assign cur_cfg = cfg_of(st_r.chset[st_r.chan]);
  assign any_en  = |en_vec;

  function automatic logic mode_clamp();
    return st_r.mode[`CS_MODE_CLAMP_BIT];
  endfunction

  always_comb begin
    logic signed [17:0] r;
    r         = filt_result;
    code      = r[15:0];
    code_sign = 1'b0;
    code_ovr  = 1'b0;
    if (cur_cfg.bipolar) begin
      // Filter gives signed value; offset code adds half scale and wraps unless clamp mode is set.
      code      = r[15:0] ^ 16'h8000;
      code_sign = r[17];
      code_ovr  = (r > 18'sh07FFF) || (r < -18'sh08000);
      if (mode_clamp() && code_ovr) begin
        code = r[17] ? 16'h0000 : 16'hFFFF;
      end
    end else begin
      code_sign = r[17];
      code_ovr  = r[17] || (r > 18'sh0FFFF);
      if (r[17]) begin
        code = 16'h0000;
      end else if (mode_clamp() && code_ovr) begin
        code = 16'hFFFF;
      end
    end
  end

  always_comb begin
    next_chan = st_r.chan;
    for (int k = NCH; k >= 1; k--) begin
      if (en_vec[3'(st_r.chan + 3'(k))]) begin
        next_chan = 3'(st_r.chan + 3'(k));
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rd_data_now;
    logic [2:0] rch;
    st_nxt      = st_r;
    rd_data_now = 1'b0;
    rch         = bus_req.addr[2:0];
    st_nxt.ref_s1 = ref_bad;
    st_nxt.ref_s2 = st_r.ref_s1;
    st_nxt.modclk = ~st_r.modclk;
    st_nxt.rdata  = 16'h0000;

    if (bus_req.rd) begin
      if (bus_req.addr == `CS_ADDR_MODE) begin
        st_nxt.rdata = {8'h00, st_r.mode};
      end else if (bus_req.addr == `CS_ADDR_CTL) begin
        st_nxt.rdata = {15'h0000, st_r.ready_pin_function_select};
      end else if (bus_req.addr == `CS_ADDR_STATUS) begin
        st_nxt.rdata = {8'h00, st_r.rdy};
      end else if (bus_req.addr[7:3] == 5'(`CS_ADDR_CHSET >> 3)) begin
        st_nxt.rdata = st_r.chset[rch];
      end else if (bus_req.addr[7:3] == 5'(`CS_ADDR_CHSTAT >> 3)) begin
        st_nxt.rdata = {9'h000, rch, st_r.reference_missing_flag[rch], st_r.sign[rch], st_r.overrange_flag[rch],
                        st_r.rdy[rch]};
      end else if (bus_req.addr[7:3] == 5'(`CS_ADDR_DATA >> 3)) begin
        st_nxt.rdata    = st_r.data[rch];
        st_nxt.rdy[rch] = 1'b0;
        rd_data_now     = 1'b1;
      end
    end

    if (st_r.ph != PH_IDLE && st_r.ref_s2) begin
      st_nxt.reference_missing_flag_seen = 1'b1;
    end

    case (st_r.ph)
      PH_IDLE: begin
        st_nxt.cnt = 14'h0000;
      end
      PH_SETTLE1: begin
        st_nxt.cnt = st_r.cnt + 14'h0001;
        // Settle ends on a modulator edge: 43 or 44 depending on phase.
        if (st_r.cnt >= 14'(`CS_SETTLE_FIRST - 1) && st_r.modclk) begin
          st_nxt.ph  = PH_SAMPLE1;
          st_nxt.cnt = 14'h0000;
        end
      end
      PH_SAMPLE1: begin
        st_nxt.cnt = st_r.cnt + 14'h0001;
        if (st_r.cnt == sample_len(cur_cfg.fw) - 14'h0001) begin
          st_nxt.ph  = cur_cfg.chop ? PH_SETTLE2 : PH_SCALE;
          st_nxt.cnt = 14'h0000;
        end
      end
      PH_SETTLE2: begin
        st_nxt.cnt = st_r.cnt + 14'h0001;
        if (st_r.cnt == 14'(`CS_SETTLE_CHOP - 1)) begin
          st_nxt.ph  = PH_SAMPLE2;
          st_nxt.cnt = 14'h0000;
        end
      end
      PH_SAMPLE2: begin
        st_nxt.cnt = st_r.cnt + 14'h0001;
        if (st_r.cnt == sample_len(cur_cfg.fw) - 14'h0001) begin
          st_nxt.ph  = PH_SCALE;
          st_nxt.cnt = 14'h0000;
        end
      end
      PH_SCALE: begin
        st_nxt.cnt = st_r.cnt + 14'h0001;
        if (st_r.cnt == 14'(`CS_SCALE_CYCLES - 1)) begin
          // A read landing on completion keeps the old word intact.
          if (!(rd_data_now && rch == st_r.chan)) begin
            st_nxt.data[st_r.chan] = code;
            st_nxt.overrange_flag[st_r.chan]  = code_ovr;
            st_nxt.sign[st_r.chan] = code_sign;
            st_nxt.rdy[st_r.chan]  = 1'b1;
          end
          st_nxt.reference_missing_flag[st_r.chan] = st_r.reference_missing_flag_seen || st_r.ref_s2;
          st_nxt.reference_missing_flag_seen       = 1'b0;
          st_nxt.cnt              = 14'h0000;
          if (st_r.mode[`CS_MODE_CONT_BIT] && any_en) begin
            st_nxt.chan = next_chan;
            st_nxt.ph   = PH_SETTLE1;
          end else begin
            st_nxt.ph   = PH_IDLE;
            st_nxt.mode = st_r.mode & ~(8'h01 << `CS_MODE_SINGLE_BIT);
          end
        end
      end
      default: st_nxt.ph = PH_IDLE;
    endcase

    if (bus_req.wr) begin
      if (bus_req.addr == `CS_ADDR_MODE) begin
        // Writing the mode restarts on the addressed channel, or idles if neither continuous nor single is set.
        st_nxt.mode = bus_req.wdata[15:8];
        st_nxt.chan = bus_req.wdata[2:0];
        st_nxt.rdy  = '0;
        st_nxt.cnt  = 14'h0000;
        st_nxt.reference_missing_flag_seen = 1'b0;
        st_nxt.ph   = (bus_req.wdata[8 + `CS_MODE_CONT_BIT] ||
                       bus_req.wdata[8 + `CS_MODE_SINGLE_BIT]) ? PH_SETTLE1 : PH_IDLE;
      end else if (bus_req.addr == `CS_ADDR_CTL) begin
        st_nxt.ready_pin_function_select = bus_req.wdata[`CS_CTL_READY_PIN_FUNCTION_SELECT_BIT];
      end else if (bus_req.addr[7:3] == 5'(`CS_ADDR_CHSET >> 3)) begin
        st_nxt.chset[rch] = bus_req.wdata;
      end
    end

    if (st_nxt.ph == PH_SCALE) begin
      st_nxt.pin_n = 1'b1;
    end else if (st_nxt.ready_pin_function_select) begin
      st_nxt.pin_n = !(any_en && ((st_nxt.rdy & en_vec) == en_vec));
    end else begin
      st_nxt.pin_n = ~|st_nxt.rdy;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r        <= '0;
      st_r.ph     <= PH_IDLE;
      st_r.mode   <= `CS_MODE_RST;
      st_r.chset  <= {NCH{16'(`CS_CHSET_RST)}};
      st_r.pin_n  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata        = st_r.rdata;
  assign ready_n      = st_r.pin_n;
  assign mux_chan     = st_r.chan;
  assign mod_clk_en   = st_r.modclk;
  assign chop_reverse = (st_r.ph == PH_SETTLE2) || (st_r.ph == PH_SAMPLE2);
  assign sampling     = (st_r.ph == PH_SAMPLE1) || (st_r.ph == PH_SAMPLE2);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_scale_pin_high: assert property (st_r.ph == PH_SCALE |-> ready_n)
    else $error("ready pin low during scaling");
  chk_scale_length: assert property ($rose(st_r.ph == PH_SCALE) && !bus_req.wr ##1
      (st_r.ph == PH_SCALE && !bus_req.wr) [*8] |-> st_r.cnt == 14'd8)
    else $error("scaling counter off");
  chk_settle2_len: assert property ($rose(st_r.ph == PH_SETTLE2) && !bus_req.wr |->
      ##42 (st_r.ph != PH_SETTLE2 || $past(bus_req.wr, 1)))
    else $error("chop settle not 42 cycles");
  chk_settle1_min: assert property ($rose(st_r.ph == PH_SAMPLE1)
      && !$past(bus_req.wr) |-> $past(st_r.ph == PH_SETTLE1, 43))
    else $error("first settle shorter than 43");
  chk_modclk_half: assert property (mod_clk_en |=> !mod_clk_en)
    else $error("modulator clock not half rate");
  chk_nochop_skip: assert property (st_r.ph == PH_SAMPLE1 && !cur_cfg.chop
      && !bus_req.wr |=> st_r.ph != PH_SETTLE2)
    else $error("unchopped channel entered second settle");
  chk_read_clears: assert property (bus_req.rd
      && bus_req.addr[7:3] == 5'(`CS_ADDR_DATA >> 3) && !(st_r.ph == PH_SCALE) && !bus_req.wr
      |=> !st_r.rdy[$past(bus_req.addr[2:0])])
    else $error("data read did not clear ready");
  chk_done_pin_low: assert property (st_r.ph == PH_SCALE && st_nxt.ph != PH_SCALE
      && !bus_req.wr && !bus_req.rd && !st_r.ready_pin_function_select |=> !ready_n)
    else $error("pin not low after completion");
  // A read of the finishing channel must leave every data word untouched.
  chk_read_discard: assert property (st_r.ph == PH_SCALE && st_nxt.ph != PH_SCALE
      && !bus_req.wr && bus_req.rd && bus_req.addr[7:3] == 5'(`CS_ADDR_DATA >> 3)
      && bus_req.addr[2:0] == st_r.chan |=> st_r.data == $past(st_r.data))
    else $error("data overwritten during read");

  cov_chopped_cycle: cover property (st_r.ph == PH_SAMPLE2 ##1 st_r.ph == PH_SCALE);
  cov_chan_advance:  cover property (st_r.ph == PH_SCALE ##1 st_r.ph == PH_SETTLE1);
  cov_clamped:       cover property (st_r.ph == PH_SCALE && mode_clamp() && code_ovr);
  cov_reference_missing_flag:         cover property ($rose(|st_r.reference_missing_flag));
  cov_read_discard:  cover property (st_r.ph == PH_SCALE && st_nxt.ph != PH_SCALE && bus_req.rd
      && bus_req.addr[7:3] == 5'(`CS_ADDR_DATA >> 3) && bus_req.addr[2:0] == st_r.chan);

endmodule // conv_seq

// ---- hdl/conv_seq_pkg.sv ----
// Types shared by the conversion sequencer and its surroundings.
// Assumes conv_seq_regs.svh is on the include path.
`include "conv_seq_regs.svh"
package conv_seq_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_SETTLE1, PH_SAMPLE1, PH_SETTLE2, PH_SAMPLE2,
                            PH_SCALE} phase_e;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;
  typedef struct packed {
    logic [7:0]  fw;
    logic        chop;
    logic        bipolar;
    logic        enable;
  } chan_cfg_s;
  // Scaled filter output: two guard bits above the 16-bit span.
  typedef logic signed [17:0] scaled_t;
endpackage

// ---- hdl/conv_seq_regs.svh ----
// Register offsets, field positions, reset values and phase timing counts
// for the conversion sequencer. Included by the package and the design file.
`ifndef CONV_SEQ_REGS_SVH
`define CONV_SEQ_REGS_SVH

`define CS_NCH             8
`define CS_SETTLE_FIRST    43
`define CS_SETTLE_CHOP     42
`define CS_SCALE_CYCLES    163
`define CS_FW_SCALE        32

`define CS_ADDR_MODE       8'h00
`define CS_ADDR_CTL        8'h01
`define CS_ADDR_STATUS     8'h02
`define CS_ADDR_CHSET      8'h10
`define CS_ADDR_CHSTAT     8'h20
`define CS_ADDR_DATA       8'h30

`define CS_MODE_RST        8'h00
`define CS_MODE_CONT_BIT   0
`define CS_MODE_SINGLE_BIT 1
`define CS_MODE_CLAMP_BIT  2
`define CS_CTL_READY_PIN_FUNCTION_SELECT_BIT   0
`define CS_CHSET_RST       16'h0120
`define CS_CHSET_FW_LSB    0
`define CS_CHSET_CHOP_BIT  8
`define CS_CHSET_BIP_BIT   9
`define CS_CHSET_EN_BIT    10
`define CS_ST_RDY_BIT      0
`define CS_ST_OVR_BIT      1
`define CS_ST_SIGN_BIT     2
`define CS_ST_REFERENCE_MISSING_FLAG_BIT    3

`endif
